// *** rtl/acds_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module acds_top (
  // Core clock and reset
  input  wire logic            mclk,
  input  wire logic            nrst,
  // Serial link
  input  wire logic            sclk,
  input  wire logic            cs_n,
  input  wire logic            din,
  // Converter handshake
  input  wire logic            conv_next,
  // Conversion descriptor
  output acds_pkg::acds_conv_type conv,
  // Status
  output logic [3:0]           mode,
  output logic [8:0]           sequence_length_field,
  output logic [7:0]           seq_index,
  output logic                 seq_busy
);
  import acds_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_PAT, ST_LOAD, ST_ARM} acds_seq_state_type;

  acds_link_type      link;
  acds_seq_state_type state_ff;
  acds_seq_state_type nxt_state;
  acds_conv_type      conv_ff;
  acds_conv_type      nxt_conv;

  logic [2:0]  sync1_ff;
  logic [2:0]  sync2_ff;
  logic [2:0]  cs_pipe_ff;
  logic        word_seen_ff;
  logic        nib_seen_ff;
  logic [3:0]  mode_ff;
  logic [3:0]  chsel_ff;
  logic [7:0]  uni_ff;
  logic [7:0]  bip_ff;
  logic [7:0]  range_ff;
  logic        com_ff;
  logic [15:0] scan_ff;
  logic [3:0]  scan_ptr_ff;
  logic        bank_ff;
  logic [7:0]  seq_idx_ff;
  logic [7:0]  len_ff [0:1];
  logic [8:0]  rcvd_ff [0:1];
  logic [3:0]  seq_mem_ff [0:1][0:SEQ_DEPTH-1];

  acds_link u_link (
    .sclk (sclk),
    .cs_n (cs_n),
    .din  (din),
    .nrst (nrst),
    .link (link)
  );

  // Pin and toggle synchronisers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // Toggles idle low and select idle high, so no false event at release
      sync1_ff <= 3'h4;
      sync2_ff <= 3'h4;
    end else begin
      sync1_ff <= {cs_n, link.word_tgl, link.nib_tgl};
      sync2_ff <= sync1_ff;
    end
  end

  // Chip select edges lag the toggles so a last nibble is never lost
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cs_pipe_ff   <= 3'h7;
      word_seen_ff <= 1'b0;
      nib_seen_ff  <= 1'b0;
    end else begin
      cs_pipe_ff   <= {cs_pipe_ff[1:0], sync2_ff[2]};
      word_seen_ff <= sync2_ff[1];
      nib_seen_ff  <= sync2_ff[0];
    end
  end

  wire cs_fall  = cs_pipe_ff[2] & ~cs_pipe_ff[1];
  wire cs_rise  = ~cs_pipe_ff[2] & cs_pipe_ff[1];
  wire word_evt = sync2_ff[1] ^ word_seen_ff;
  wire nib_evt  = sync2_ff[0] ^ nib_seen_ff;

  // Register word decode; the pattern frame carries no register writes
  wire [4:0] word_sel  = link.word[SEL_HI:SEL_LO];
  wire [7:0] word_fld  = link.word[FLD_HI:FLD_LO];
  wire [3:0] word_mode = link.word[MODE_HI:MODE_LO];
  wire [3:0] word_chan = link.word[CHSEL_HI:CHSEL_LO];
  wire       word_com  = link.word[COM_BIT];
  wire       reg_wr    = word_evt & (state_ff != ST_LOAD);
  wire       wr_mode   = reg_wr & (word_sel == SEL_MODE);
  wire       wr_uni    = reg_wr & (word_sel == SEL_UNI);
  wire       wr_bip    = reg_wr & (word_sel == SEL_BIP);
  wire       wr_range  = reg_wr & (word_sel == SEL_RANGE);
  wire       wr_scan0  = reg_wr & (word_sel == SEL_SCAN0);
  wire       wr_scan1  = reg_wr & (word_sel == SEL_SCAN1);
  wire       wr_seq    = reg_wr & (word_sel == SEL_SEQ);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mode_ff  <= RST_MODE;
      chsel_ff <= RST_CHSEL;
      uni_ff   <= RST_PAIR;
      bip_ff   <= RST_PAIR;
      range_ff <= RST_PAIR;
      com_ff   <= RST_COM;
      scan_ff  <= RST_SCAN;
    end else begin
      if (wr_mode) begin
        mode_ff  <= word_mode;
        chsel_ff <= word_chan;
      end
      if (wr_uni) begin
        uni_ff <= word_fld;
        com_ff <= word_com;
      end
      if (wr_bip) begin
        bip_ff <= word_fld;
      end
      if (wr_range) begin
        range_ff <= word_fld;
      end
      if (wr_scan0) begin
        scan_ff[15:8] <= word_fld;
      end
      if (wr_scan1) begin
        scan_ff[7:0] <= word_fld;
      end
    end
  end

  // Sequencer loading: length frame, pattern frame, then arm
  wire       stage_bank = ~bank_ff;
  wire [8:0] stage_room = {1'b0, len_ff[stage_bank]} + 9'h001;
  wire       stage_full = (rcvd_ff[stage_bank] >= stage_room);
  wire       nib_store  = nib_evt & (state_ff == ST_LOAD) & ~stage_full;
  wire       swap       = (state_ff == ST_ARM) & cs_fall;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:     if (wr_seq) nxt_state = ST_WAIT_PAT;
      ST_WAIT_PAT: if (cs_fall) nxt_state = ST_LOAD;
      ST_LOAD:     if (cs_rise) nxt_state = ST_ARM;
      ST_ARM:      if (cs_fall) nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      bank_ff  <= 1'b0;
      for (int b = 0; b < 2; b++) begin
        len_ff[b]  <= RST_LEN;
        rcvd_ff[b] <= 9'h000;
      end
    end else begin
      state_ff <= nxt_state;
      if (swap) begin
        bank_ff <= stage_bank;
      end
      if (wr_seq) begin
        len_ff[stage_bank] <= word_fld;
      end
      if ((state_ff == ST_WAIT_PAT) && cs_fall) begin
        rcvd_ff[stage_bank] <= 9'h000;
      end else if (nib_store) begin
        rcvd_ff[stage_bank] <= rcvd_ff[stage_bank] + 9'h001;
      end
    end
  end

  // Pattern memory has no reset; unwritten slots are masked by the count
  always_ff @(posedge mclk) begin
    if (nib_store) begin
      seq_mem_ff[stage_bank][rcvd_ff[stage_bank][7:0]] <= link.nib;
    end
  end

  // Channel choice per mode
  function automatic logic [3:0] next_scan(input logic [15:0] en, input logic [3:0] from);
    logic [3:0] res;
    logic [3:0] cand;
    logic       found;
    res   = from;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      cand = from + i[3:0];
      if (!found && en[cand]) begin
        res   = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  wire       is_custom = (mode_ff == MODE_CHOSEN_INT) | (mode_ff == MODE_CHOSEN_EXT);
  wire       is_user   = (mode_ff == MODE_USER_SEQ);
  wire [3:0] cust_chan = scan_ff[scan_ptr_ff] ? scan_ptr_ff : next_scan(scan_ff, scan_ptr_ff);
  wire [7:0] act_len   = len_ff[bank_ff];
  wire [3:0] seq_raw   = seq_mem_ff[bank_ff][seq_idx_ff];
  wire       seq_held  = ({1'b0, seq_idx_ff} < rcvd_ff[bank_ff]);
  wire [3:0] seq_entry = seq_held ? seq_raw : CH_ZERO;
  wire [3:0] chan_sel  = is_user ? seq_entry : (is_custom ? cust_chan : chsel_ff);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scan_ptr_ff <= 4'h0;
      seq_idx_ff  <= 8'h00;
    end else begin
      if (conv_next && is_custom) begin
        scan_ptr_ff <= next_scan(scan_ff, cust_chan);
      end
      if (swap) begin
        seq_idx_ff <= 8'h00;
      end else if (conv_next && is_user) begin
        seq_idx_ff <= (seq_idx_ff == act_len) ? 8'h00 : seq_idx_ff + 8'h01;
      end
    end
  end

  // Pair decode, the same for every even/odd pair
  wire [2:0] pair    = chan_sel[3:1];
  wire [2:0] pair_ix = 3'h7 - pair;
  wire       dec_uni = uni_ff[pair_ix];
  wire       dec_bip = bip_ff[pair_ix];
  wire       dec_rng = range_ff[pair_ix];
  wire       dec_com = com_ff;
  wire       dec_pair = ~dec_com & (dec_uni | dec_bip);
  wire       dec_twos = ~dec_com & ~dec_uni & dec_bip;

  always_comb begin
    nxt_conv            = '0;
    nxt_conv.valid      = ~is_custom | (|scan_ff);
    nxt_conv.pos        = dec_pair ? {pair, 1'b0} : chan_sel;
    nxt_conv.neg        = dec_com ? CH_REF : (dec_pair ? {pair, 1'b1} : CH_ZERO);
    nxt_conv.pair_diff  = dec_pair;
    nxt_conv.com_ref    = dec_com;
    nxt_conv.twos_comp  = dec_twos;
    nxt_conv.wide_range = dec_twos & dec_rng;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      conv_ff <= '0;
    end else begin
      conv_ff <= nxt_conv;
    end
  end

  assign conv       = conv_ff;
  assign mode       = mode_ff;
  assign sequence_length_field = {1'b0, act_len} + 9'h001;
  assign seq_index  = seq_idx_ff;
  assign seq_busy   = (state_ff != ST_IDLE);

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_mode_write: assert property (
    wr_mode |=> (mode_ff == $past(word_mode)) && (chsel_ff == $past(word_chan)))
    else $error("mode write not taken");

  a_uni_write: assert property (
    (wr_uni && !wr_bip) |=> (uni_ff == $past(word_fld)) && $stable(bip_ff))
    else $error("unipolar write wrong");

  a_com_write: assert property (
    wr_uni |=> com_ff == $past(word_com))
    else $error("common reference bit not loaded");

  a_chsel_path: assert property (
    (!is_user && !is_custom && !dec_pair) |=> conv_ff.pos == $past(chsel_ff))
    else $error("channel select not followed");

  a_custom_pick: assert property (
    (is_custom && (|scan_ff)) |-> scan_ff[cust_chan])
    else $error("custom channel not enabled");

  a_bip_twos: assert property (
    (!dec_com && !dec_uni && dec_bip) |=> conv_ff.twos_comp && conv_ff.pair_diff
      && (conv_ff.neg == conv_ff.pos + 4'h1))
    else $error("bipolar pair decode wrong");

  a_uni_wins: assert property (
    (!dec_com && dec_uni) |=> conv_ff.pair_diff && !conv_ff.twos_comp)
    else $error("unipolar did not take precedence");

  a_single_end: assert property (
    (!dec_com && !dec_uni && !dec_bip) |=> !conv_ff.pair_diff && !conv_ff.twos_comp
      && (conv_ff.neg == CH_ZERO))
    else $error("single-ended decode wrong");

  a_com_ref: assert property (
    dec_com |=> conv_ff.com_ref && (conv_ff.neg == CH_REF) && !conv_ff.twos_comp
      && (conv_ff.pos == $past(chan_sel)))
    else $error("common reference decode wrong");

  a_range_gate: assert property (
    conv_ff.wide_range |-> conv_ff.twos_comp && !conv_ff.com_ref)
    else $error("range applied outside bipolar pair");

  a_surplus_drop: assert property (
    (nib_evt && (state_ff == ST_LOAD) && stage_full) |=> $stable(rcvd_ff[stage_bank]))
    else $error("surplus nibble stored");

  a_fill_zero: assert property (
    !seq_held |-> seq_entry == CH_ZERO)
    else $error("missing entry not channel 0");

  a_swap_fall: assert property (
    swap |=> (bank_ff != $past(bank_ff)) && (seq_idx_ff == 8'h00) ##1 (state_ff == ST_IDLE))
    else $error("pattern not activated at select fall");

  a_two_frames: assert property (
    ((state_ff == ST_IDLE) && wr_seq) |=> (state_ff == ST_WAIT_PAT))
    else $error("length frame not recognised");

  a_seq_wrap: assert property (
    (is_user && conv_next && !swap && (seq_idx_ff == act_len)) |=> seq_idx_ff == 8'h00)
    else $error("sequence did not wrap");

endmodule // acds_top
`default_nettype wire

// *** shared/acds_pkg.sv ***
`default_nettype none
package acds_pkg;
  localparam int WORD_W = 16;
  localparam int NIB_W  = 4;
  localparam int SEQ_DEPTH = 256;
  localparam int SEQ_AW = 8;
  // Serial word fields
  localparam int SEL_HI   = 15;
  localparam int SEL_LO   = 11;
  localparam int FLD_HI   = 10;
  localparam int FLD_LO   = 3;
  localparam int COM_BIT  = 2;
  localparam int MODE_HI  = 10;
  localparam int MODE_LO  = 7;
  localparam int CHSEL_HI = 6;
  localparam int CHSEL_LO = 3;
  // Register select codes
  localparam logic [4:0] SEL_MODE  = 5'h01;
  localparam logic [4:0] SEL_UNI   = 5'h11;
  localparam logic [4:0] SEL_BIP   = 5'h12;
  localparam logic [4:0] SEL_RANGE = 5'h13;
  localparam logic [4:0] SEL_SCAN0 = 5'h14;
  localparam logic [4:0] SEL_SCAN1 = 5'h15;
  localparam logic [4:0] SEL_SEQ   = 5'h16;
  // Operating mode codes, then fixed channel codes
  localparam logic [3:0] MODE_MANUAL     = 4'h0;
  localparam logic [3:0] MODE_REPEAT     = 4'h1;
  localparam logic [3:0] MODE_ASC_INT    = 4'h2;
  localparam logic [3:0] MODE_ASC_EXT    = 4'h3;
  localparam logic [3:0] MODE_TOP_INT    = 4'h4;
  localparam logic [3:0] MODE_TOP_EXT    = 4'h5;
  localparam logic [3:0] MODE_CHOSEN_INT = 4'h6;
  localparam logic [3:0] MODE_CHOSEN_EXT = 4'h7;
  localparam logic [3:0] MODE_USER_SEQ   = 4'h8;
  localparam logic [3:0] CH_REF    = 4'hf;
  localparam logic [3:0] CH_ZERO   = 4'h0;
  // Reset values
  localparam logic [3:0]  RST_MODE  = 4'h0;
  localparam logic [3:0]  RST_CHSEL = 4'h0;
  localparam logic [7:0]  RST_PAIR  = 8'h00;
  localparam logic        RST_COM   = 1'b0;
  localparam logic [15:0] RST_SCAN  = 16'h0000;
  localparam logic [7:0]  RST_LEN   = 8'h00;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              word_tgl;
    logic [NIB_W-1:0]  nib;
    logic              nib_tgl;
  } acds_link_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] pos;
    logic [3:0] neg;
    logic       pair_diff;
    logic       com_ref;
    logic       twos_comp;
    logic       wide_range;
  } acds_conv_type;
endpackage
`default_nettype wire

// *** rtl/acds_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module acds_link (
  // Serial pins
  input  wire logic            sclk,
  input  wire logic            cs_n,
  input  wire logic            din,
  // Core reset
  input  wire logic            nrst,
  // Toward core
  output acds_pkg::acds_link_type link
);
  import acds_pkg::*;

  logic [3:0]        bit_cnt_ff;
  logic [14:0]       shift_ff;
  logic [WORD_W-1:0] word_ff;
  logic              word_tgl_ff;
  logic [NIB_W-1:0]  nib_ff;
  logic              nib_tgl_ff;

  wire word_done = (bit_cnt_ff == 4'hf);
  wire nib_done  = (bit_cnt_ff[1:0] == 2'h3);

  // The link clock stops between frames, so chip select clears the framing
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 15'h0000;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      shift_ff   <= {shift_ff[13:0], din};
    end
  end

  // Only complete nibbles are ever reported; a cut one never leaves here
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      word_ff     <= 16'h0000;
      word_tgl_ff <= 1'b0;
      nib_ff      <= 4'h0;
      nib_tgl_ff  <= 1'b0;
    end else if (!cs_n) begin
      if (word_done) begin
        word_ff     <= {shift_ff, din};
        word_tgl_ff <= ~word_tgl_ff;
      end
      if (nib_done) begin
        nib_ff     <= {shift_ff[2:0], din};
        nib_tgl_ff <= ~nib_tgl_ff;
      end
    end
  end

  assign link.word     = word_ff;
  assign link.word_tgl = word_tgl_ff;
  assign link.nib      = nib_ff;
  assign link.nib_tgl  = nib_tgl_ff;
endmodule // acds_link
`default_nettype wire

// *** bench/acds_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module acds_host (
  // Serial pins toward device
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // Offsets keep the link out of phase with the core clock
  task automatic frame_begin;
    #37 cs_n = 1'b0;
    #26;
  endtask
  // Link clock runs only inside frames
  task automatic send_bit(input logic b);
    din = b;
    #15 sclk = 1'b1;
    #15 sclk = 1'b0;
  endtask
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) send_bit(w[i]);
  endtask
  task automatic send_nib(input logic [3:0] v);
    for (int i = 3; i >= 0; i--) send_bit(v[i]);
  endtask
  task automatic frame_end;
    #15 cs_n = 1'b1;
    // Released line has no pull, so show the inverse
    din = ~din;
    #202;
  endtask
endmodule // acds_host
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acds_pkg::*;
  logic          mclk;
  logic          nrst;
  logic          conv_next;
  wire logic     sclk;
  wire logic     cs_n;
  wire logic     din;
  acds_conv_type conv;
  logic [3:0]    mode;
  logic [8:0]    sequence_length_field;
  logic [7:0]    seq_index;
  logic          seq_busy;
  int            err_count;
  int            tests_run;
  logic [3:0]    ch;
  logic [7:0]    pmask;
  logic [7:0]    uni;
  logic [7:0]    bip;
  logic [7:0]    rng;
  logic          com;
  logic [3:0]    seq_a [5] = '{4'h9, 4'hc, 4'h0, 4'h0, 4'h3};
  logic [3:0]    scan_a [4] = '{4'h6, 4'hc, 4'h3, 4'h6};

  acds_host host (.sclk(sclk), .cs_n(cs_n), .din(din));
  acds_top dut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .conv_next(conv_next), .conv(conv), .mode(mode), .sequence_length_field(sequence_length_field),
    .seq_index(seq_index), .seq_busy(seq_busy));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic acds_conv_type dec(input logic [3:0] c, input logic [7:0] u,
    input logic [7:0] b, input logic [7:0] r, input logic com);
    acds_conv_type d;
    logic [2:0] p;
    p = 3'h7 - c[3:1];
    d = '0;
    d.valid = 1'b1;
    d.pos = c;
    if (com) begin
      d.neg = CH_REF;
      d.com_ref = 1'b1;
    end else if (u[p] | b[p]) begin
      d.pos = {c[3:1], 1'b0};
      d.neg = {c[3:1], 1'b1};
      d.pair_diff = 1'b1;
      d.twos_comp = ~u[p];
      d.wide_range = ~u[p] & r[p];
    end
    return d;
  endfunction
  // Expected decode under the register values last written
  function automatic acds_conv_type cur(input logic [3:0] c);
    return dec(c, uni, bip, rng, com);
  endfunction

  task automatic cmp_conv(input acds_conv_type got, input acds_conv_type exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_conv(input acds_conv_type exp);
    for (int n = 0; n < 30 && conv !== exp; n++) @(negedge mclk);
    cmp_conv(conv, exp);
  endtask
  task automatic pulse;
    @(negedge mclk) conv_next = 1'b1;
    @(negedge mclk) conv_next = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic wr1(input logic [15:0] w);
    host.frame_begin();
    host.send_word(w);
    host.frame_end();
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #900000;
    err_count++;
    complete_run();
  end

  initial begin
    nrst = 1'b0;
    conv_next = 1'b0;
    err_count = 0;
    tests_run = 0;
    uni = '0;
    bip = '0;
    rng = '0;
    com = 1'b0;
    repeat (20) @(negedge mclk);
    cmp_conv(conv, '0);
    nrst = 1'b1;
    repeat (5) @(negedge mclk);
    wait_conv(cur(4'h0));
    cmp_val(9'(sequence_length_field), 9'h001);
    cmp_val(9'(seq_busy), 9'h000);
    // Other pairs carry the opposite bipolar bit to catch wrong pair
    for (int i = 0; i < 8; i++) begin
      ch = (i == 7) ? 4'he : 4'(2 * i + i % 2);
      pmask = 8'h80 >> ch[3:1];
      uni = i[0] ? pmask : 8'h00;
      bip = i[1] ? pmask : ~pmask;
      rng = pmask;
      com = i[2];
      host.frame_begin();
      host.send_word({SEL_UNI, uni, i[2], 2'b00});
      host.send_word({SEL_BIP, bip, 3'b000});
      host.send_word({SEL_RANGE, pmask, 3'b000});
      host.send_word({SEL_MODE, MODE_MANUAL, ch, 3'b000});
      host.frame_end();
      wait_conv(cur(ch));
    end
    host.frame_begin();
    host.send_word({SEL_UNI, 11'h000});
    host.send_word({SEL_BIP, 11'h000});
    host.frame_end();
    uni = '0;
    bip = '0;
    com = 1'b0;
    for (int m = 0; m < 16; m++) begin
      ch = 4'(m) ^ 4'h5;
      wr1({SEL_MODE, 4'(m), ch, 3'b000});
      if (m == 6 || m == 7) begin
        cmp_val(9'(conv.valid), 9'h000);
      end else begin
        wait_conv(cur((m == 8) ? 4'h0 : ch));
      end
      cmp_val(9'(mode), 9'(m));
    end
    host.frame_begin();
    host.send_word({SEL_SCAN0, 8'h10, 3'b000});
    host.send_word({SEL_SCAN1, 8'h48, 3'b000});
    host.send_word({SEL_MODE, MODE_CHOSEN_EXT, 4'h0, 3'b000});
    host.frame_end();
    for (int k = 0; k < 4 && conv.pos !== 4'h3; k++) pulse();
    for (int k = 0; k < 4; k++) begin
      pulse();
      wait_conv(cur(scan_a[k]));
    end
    // Five entries, last two from a cut nibble and a missing one
    wr1({SEL_SEQ, 8'h04, 3'b000});
    cmp_val(9'(seq_busy), 9'h001);
    host.frame_begin();
    host.send_nib(4'h3);
    host.send_nib(4'h9);
    host.send_nib(4'hc);
    host.send_bit(1'b1);
    host.send_bit(1'b1);
    host.frame_end();
    cmp_val(sequence_length_field, 9'h001);
    wr1({SEL_MODE, MODE_USER_SEQ, 4'h0, 3'b000});
    cmp_val(9'(seq_busy), 9'h000);
    cmp_val(sequence_length_field, 9'h005);
    cmp_val(9'(seq_index), 9'h000);
    wait_conv(cur(4'h3));
    for (int k = 0; k < 5; k++) begin
      pulse();
      wait_conv(cur(seq_a[k]));
      cmp_val(9'(seq_index), 9'((k + 1) % 5));
    end
    // Surplus that looks like a mode write must be dropped
    wr1({SEL_SEQ, 8'h01, 3'b000});
    host.frame_begin();
    host.send_nib(4'h7);
    host.send_nib(4'h4);
    host.send_word({SEL_MODE, MODE_MANUAL, 4'h1, 3'b000});
    host.frame_end();
    wr1({SEL_RANGE, 11'h000});
    rng = '0;
    cmp_val(9'(mode), 9'(MODE_USER_SEQ));
    cmp_val(sequence_length_field, 9'h002);
    wait_conv(cur(4'h7));
    pulse();
    wait_conv(cur(4'h4));
    pulse();
    wait_conv(cur(4'h7));
    // Longest sequence with an empty pattern frame
    wr1({SEL_SEQ, 8'hff, 3'b000});
    host.frame_begin();
    host.frame_end();
    wr1({SEL_RANGE, 11'h000});
    cmp_val(sequence_length_field, 9'h100);
    wait_conv(cur(4'h0));
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
